// >>> hw/tws_pkg.sv
// Summary of operation
// - Start is SDA falling while SCL high
// - Only the master creates start conditions
// - Compare received 7-bit address with own address
// - On match store R/W, ack, interrupt
// - Set address match flag on equal address
// - One interrupt for match and byte done
// - Hold SCL until data write or read
// - Read request means transmit, else receive
// - Master stops when address not acknowledged
// - Software sets transmit mode from read request
// - Bytes are 8 bits, MSB first
// - Receiver acks from ack drive select bit
// - Transmitter releases SDA on missing acknowledge
// - All bus data passes the data register
// - On no ack, switch to receive, dummy read
// - Byte done clears in transfer, sets after
// - Stop clears the bus busy flag
// - Received ack flag: 0 ack, 1 none
// - Ack drive select: 0 ack, 1 none
package tws_pkg;
  typedef logic [7:0] tws_byte_t;
  typedef logic [31:0] tws_word_t;
  // Device register map
  localparam tws_byte_t OFS_OWN_ADDR = 8'h20;
  localparam tws_byte_t OFS_CTRL = 8'h21;
  localparam tws_byte_t OFS_STATUS = 8'h22;
  localparam tws_byte_t OFS_DATA = 8'h23;
  localparam int CTRL_ACK_BIT = 3;
  localparam int CTRL_TX_BIT = 4;
  localparam int CTRL_EN_BIT = 7;
  localparam tws_byte_t CTRL_MASK = 8'h98;
  localparam int ST_RECEIVED_ACK_FLAG_BIT = 0;
  localparam int ST_SRW_BIT = 2;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_MATCH_BIT = 6;
  localparam int ST_DONE_BIT = 7;
  localparam tws_byte_t RESET_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Controller register map (AXI4-Lite byte addresses)
  localparam tws_byte_t OFS_CMD = 8'h00;
  localparam tws_byte_t OFS_TXDATA = 8'h04;
  localparam tws_byte_t OFS_MSTAT = 8'h08;
  localparam tws_byte_t OFS_RXDATA = 8'h0c;
  localparam int CMD_ACK_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Controller commands
  typedef enum logic [1:0] {
    OP_START = 2'b00, OP_WRITE = 2'b01, OP_READ = 2'b10, OP_STOP = 2'b11
  } tws_op_e;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam logic [3:0] HALF_CYC = 4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  // Device end states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_ACK = 3'b010, S_DATA = 3'b011, S_WAIT = 3'b100
  } tws_sst_e;
  // Controller end states
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_S0 = 3'b001, M_S1 = 3'b010, M_S2 = 3'b011,
    M_BLO = 3'b100, M_BHI = 3'b101, M_P1 = 3'b110, M_P2 = 3'b111
  } tws_mst_e;
endpackage : tws_pkg

// >>> hw/tws_if.sv
`timescale 1ns/1ns
`default_nettype none
// Open-drain two-wire link; a line is low while any end enables its driver
interface tws_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_scl_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND of both ends
  assign scl = ~(m_scl_oe | s_scl_oe);
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_scl_oe, output s_sda_oe, input scl, input sda);
endinterface : tws_if
`default_nettype wire

// >>> hw/tws_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser on both lines plus edge and condition detection
module tws_sync (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  // Synchroniser chain, then one history stage
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
    end
  end
  // Edges and bus conditions from the settled stages only
  assign scl_out = scl_s_q;
  assign sda_out = sda_s_q;
  assign scl_rise_out = scl_s_q & ~scl_p_q;
  assign scl_fall_out = ~scl_s_q & scl_p_q;
  assign start_out = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_out = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
endmodule : tws_sync
`default_nettype wire

// >>> hw/tws_slave.sv
`timescale 1ns/1ns
`default_nettype none
// Device end: addressed slave with byte register interface
module tws_slave (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  tws_if.slave bus,
  input wire tws_pkg::tws_byte_t reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire tws_pkg::tws_byte_t reg_wdata_in,
  output tws_pkg::tws_byte_t reg_rdata_out,
  output logic irq_out
);
  import tws_pkg::*;

  tws_sst_e state_q;
  tws_byte_t own_q;
  tws_byte_t ctrl_q;
  tws_byte_t data_q;
  tws_byte_t sh_q;
  tws_byte_t rdata_q;
  logic [3:0] cnt_q;
  logic busy_q, match_q, done_q, srw_q, received_ack_flag_q;
  logic stretch_q, sda_oe_q, irq_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  // Line sampling
  tws_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl_out(scl_s),
    .sda_out(sda_s),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_det),
    .stop_out(stop_det)
  );

  // Register decode
  wire wr_own = reg_wr_in && (reg_addr_in == OFS_OWN_ADDR);
  wire wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);
  wire wr_data = reg_wr_in && (reg_addr_in == OFS_DATA);
  wire rd_data = reg_rd_in && (reg_addr_in == OFS_DATA);
  wire enable = ctrl_q[CTRL_EN_BIT];
  wire tx_mode = ctrl_q[CTRL_TX_BIT];
  wire ack_sel = ctrl_q[CTRL_ACK_BIT];
  wire addr_hit = (sh_q[7:1] == own_q[7:1]);
  wire byte_end = scl_fall && (cnt_q == BITS_PER_BYTE);
  // Stretch is released by a data write when sending, a read when receiving
  wire resume = stretch_q && ((wr_data && tx_mode) || (rd_data && !tx_mode));

  // Status word: done, match, busy, read request, received ack
  tws_byte_t status;
  assign status = {done_q, match_q, busy_q, 2'b00, srw_q, 1'b0, received_ack_flag_q};

  // Read selection
  tws_byte_t rd_mux;
  assign rd_mux = (reg_addr_in == OFS_OWN_ADDR) ? {own_q[7:1], 1'b0} :
                  (reg_addr_in == OFS_CTRL) ? ctrl_q :
                  (reg_addr_in == OFS_STATUS) ? status :
                  (reg_addr_in == OFS_DATA) ? data_q : RESET_BYTE;

  // Software side of the register file
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      own_q <= RESET_BYTE;
      ctrl_q <= RESET_BYTE;
      rdata_q <= RESET_BYTE;
    end else begin
      if (wr_own) begin
        own_q <= reg_wdata_in;
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in & CTRL_MASK;
      end
      if (reg_rd_in) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Bus engine, flags and data register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= S_IDLE;
      data_q <= RESET_BYTE;
      sh_q <= RESET_BYTE;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      match_q <= 1'b0;
      done_q <= 1'b0;
      srw_q <= 1'b0;
      received_ack_flag_q <= 1'b0;
      stretch_q <= 1'b0;
      sda_oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      // Any control write or data access acknowledges the interrupt
      if (wr_ctrl || wr_data || rd_data) begin
        irq_q <= 1'b0;
      end
      if (wr_ctrl) begin
        match_q <= 1'b0;
      end
      if (wr_data) begin
        data_q <= reg_wdata_in;
      end
      // Software releases the clock and starts the next byte
      if (resume) begin
        stretch_q <= 1'b0;
        done_q <= 1'b0;
        cnt_q <= 4'h0;
        if (tx_mode) begin
          sh_q <= reg_wdata_in;
          sda_oe_q <= ~reg_wdata_in[7];
        end
      end
      if (stop_det) begin
        busy_q <= 1'b0;
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
        stretch_q <= 1'b0;
      end else if (start_det) begin
        busy_q <= 1'b1;
        state_q <= enable ? S_ADDR : S_WAIT;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        stretch_q <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end) begin
              if (addr_hit) begin
                match_q <= 1'b1;
                done_q <= 1'b1;
                srw_q <= sh_q[0];
                sda_oe_q <= 1'b1;
                irq_q <= 1'b1;
                state_q <= S_ACK;
              end else begin
                match_q <= 1'b0;
                state_q <= S_WAIT;
              end
            end
          end
          S_ACK: begin
            if (scl_rise && tx_mode && !sda_oe_q) begin
              received_ack_flag_q <= sda_s;
            end else if (scl_fall) begin
              sda_oe_q <= 1'b0;
              stretch_q <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= S_DATA;
            end
          end
          S_DATA: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
              if (!tx_mode) begin
                sh_q <= {sh_q[6:0], sda_s};
              end
            end else if (byte_end) begin
              done_q <= 1'b1;
              irq_q <= 1'b1;
              state_q <= S_ACK;
              if (tx_mode) begin
                sda_oe_q <= 1'b0;
              end else begin
                data_q <= sh_q;
                sda_oe_q <= ~ack_sel;
              end
            end else if (scl_fall && tx_mode) begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
            end
          end
          default: begin
            // Idle or not addressed: line left alone until stop or start
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Outputs
  assign bus.s_scl_oe = stretch_q;
  assign bus.s_sda_oe = sda_oe_q;
  assign reg_rdata_out = rdata_q;
  assign irq_out = irq_q;
endmodule : tws_slave
`default_nettype wire

// >>> hw/tws_master.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Controller end: drives the two-wire link from AXI4-Lite commands
module tws_master (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  tws_if.master bus,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire tws_pkg::tws_byte_t s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire tws_pkg::tws_word_t s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire tws_pkg::tws_byte_t s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output tws_pkg::tws_word_t s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  import tws_pkg::*;

  tws_mst_e st_q;
  tws_byte_t awaddr_q, wdat_q, txdata_q, rx_q;
  logic [8:0] tx_q;
  logic [3:0] bcnt_q, tmr_q;
  logic aw_got_q, w_got_q, wstb_q, bvalid_q, rvalid_q, busy_q;
  logic scl_oe_q, sda_oe_q, rxack_q;
  logic [1:0] bresp_q, rresp_q;
  tws_word_t rdata_q;
  logic scl_s, sda_s;

  // Line sampling
  tws_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl_out(scl_s),
    .sda_out(sda_s),
    .scl_rise_out(),
    .scl_fall_out(),
    .start_out(),
    .stop_out()
  );

  // Write and read address decode
  wire do_wr = aw_got_q && w_got_q && !bvalid_q;
  wire wr_ok = (awaddr_q == OFS_CMD) || (awaddr_q == OFS_TXDATA);
  wire cmd_go = do_wr && wstb_q && (awaddr_q == OFS_CMD) && !busy_q;
  wire ar_take = s_axi_arvalid_in && !rvalid_q;
  wire rd_ok = (s_axi_araddr_in == OFS_CMD) || (s_axi_araddr_in == OFS_TXDATA) ||
               (s_axi_araddr_in == OFS_MSTAT) || (s_axi_araddr_in == OFS_RXDATA);
  tws_word_t rd_mux;
  assign rd_mux = (s_axi_araddr_in == OFS_TXDATA) ? {24'h0, txdata_q} :
                  (s_axi_araddr_in == OFS_MSTAT) ? {30'h0, rxack_q, busy_q} :
                  (s_axi_araddr_in == OFS_RXDATA) ? {24'h0, rx_q} : 32'h0;
  tws_op_e op;
  assign op = tws_op_e'(wdat_q[1:0]);

  // Phase timer; the phase entered on releasing SCL (M_S1, M_BHI, M_P2) waits for the line to go high
  wire need_high = (st_q == M_BHI) || (st_q == M_S1) || (st_q == M_P2);
  wire run = need_high ? scl_s : 1'b1;
  wire adv = run && (tmr_q == HALF_CYC - 4'h1);

  // AXI4-Lite slave handshakes
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {aw_got_q, w_got_q, wstb_q, bvalid_q, rvalid_q} <= 5'h0;
      awaddr_q <= RESET_BYTE;
      wdat_q <= RESET_BYTE;
      txdata_q <= RESET_BYTE;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      if (s_axi_awvalid_in && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_got_q) begin
        w_got_q <= 1'b1;
        wdat_q <= s_axi_wdata_in[7:0];
        wstb_q <= s_axi_wstrb_in[0];
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wstb_q && awaddr_q == OFS_TXDATA) begin
          txdata_q <= wdat_q;
        end
      end
      if (bvalid_q && s_axi_bready_in) begin
        {bvalid_q, aw_got_q, w_got_q} <= 3'h0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Link sequencer
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= M_IDLE;
      {busy_q, scl_oe_q, sda_oe_q, rxack_q} <= 4'h0;
      tx_q <= 9'h0;
      rx_q <= RESET_BYTE;
      bcnt_q <= 4'h0;
      tmr_q <= 4'h0;
    end else begin
      tmr_q <= (!run || adv || st_q == M_IDLE) ? 4'h0 : tmr_q + 4'h1;
      case (st_q)
        M_IDLE: begin
          if (cmd_go) begin
            busy_q <= 1'b1;
            bcnt_q <= 4'h0;
            case (op)
              OP_START: begin
                sda_oe_q <= 1'b0;
                st_q <= M_S0;
              end
              OP_WRITE: begin
                tx_q <= {txdata_q, 1'b1};
                sda_oe_q <= ~txdata_q[7];
                scl_oe_q <= 1'b1;
                st_q <= M_BLO;
              end
              OP_READ: begin
                tx_q <= {8'hff, wdat_q[CMD_ACK_BIT]};
                sda_oe_q <= 1'b0;
                scl_oe_q <= 1'b1;
                st_q <= M_BLO;
              end
              default: begin
                scl_oe_q <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q <= M_P1;
              end
            endcase
          end
        end
        M_S0: if (adv) begin
          scl_oe_q <= 1'b0;
          st_q <= M_S1;
        end
        M_S1: if (adv) begin
          sda_oe_q <= 1'b1;
          st_q <= M_S2;
        end
        M_S2: if (adv) begin
          scl_oe_q <= 1'b1;
          busy_q <= 1'b0;
          st_q <= M_IDLE;
        end
        M_BLO: if (adv) begin
          scl_oe_q <= 1'b0;
          st_q <= M_BHI;
        end
        M_BHI: if (adv) begin
          // Sample at the end of the high phase, after any stretch
          rx_q <= (bcnt_q < BITS_PER_BYTE) ? {rx_q[6:0], sda_s} : rx_q;
          scl_oe_q <= 1'b1;
          if (bcnt_q == BITS_PER_BYTE) begin
            rxack_q <= sda_s;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
            st_q <= M_IDLE;
          end else begin
            tx_q <= {tx_q[7:0], 1'b1};
            sda_oe_q <= ~tx_q[7];
            bcnt_q <= bcnt_q + 4'h1;
            st_q <= M_BLO;
          end
        end
        M_P1: if (adv) begin
          scl_oe_q <= 1'b0;
          st_q <= M_P2;
        end
        default: if (adv) begin
          sda_oe_q <= 1'b0;
          busy_q <= 1'b0;
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // Outputs
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
  assign s_axi_awready_out = !aw_got_q;
  assign s_axi_wready_out = !w_got_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
endmodule : tws_master
`default_nettype wire

// >>> test/tws_props.sv
`timescale 1ns/1ns
`default_nettype none
// Watches both ends' drivers and the resolved two-wire link
module tws_props (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_scl_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  // Line conditions and a drive held over a clock high phase
  sequence start_seen;
    $fell(sda) && scl;
  endsequence
  sequence stop_seen;
    $rose(sda) && scl;
  endsequence
  sequence drive_held;
    s_sda_oe [*3];
  endsequence
  a_idle_after_reset: assert property ($rose(rst_b_in) |->
    !m_scl_oe && !m_sda_oe && !s_scl_oe && !s_sda_oe) else $error("drivers active after reset");
  a_start_by_master: assert property (start_seen |-> m_sda_oe && !s_sda_oe)
    else $error("start not made by master");
  a_stop_by_master: assert property (stop_seen |-> $past(m_sda_oe) && !s_sda_oe)
    else $error("stop not made by master");
  a_slave_sda_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave changed data while clock high");
  a_slave_ack_held: assert property (s_sda_oe && $rose(scl) |-> drive_held)
    else $error("slave drive not held over clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*3])
    else $error("clock high phase too short");
  a_stretch_in_low: assert property ($rose(s_scl_oe) |-> m_scl_oe && !scl)
    else $error("stretch began outside clock low");
  a_stretch_gap: assert property ($fell(s_scl_oe) |-> !s_scl_oe [*8])
    else $error("stretch resumed too soon");
endmodule : tws_props
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
// Controller over AXI4-Lite facing the device end over the link
module tb_top;
  import tws_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'h1;
  tws_byte_t awaddr = 8'h00, araddr = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
  tws_byte_t reg_rdata, sv, d0;
  tws_word_t wdata = 32'h0, rdata, rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0, irq;
  logic [6:0] own;
  logic [34:0] exp_q[$];
  logic [34:0] ent;
  int failures = 0, samples_checked = 0;
  tws_if link_if();
  tws_master tws_master_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus(link_if.master),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
  tws_slave tws_slave_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus(link_if.slave),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .irq_out(irq));
  tws_props tws_props_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .m_scl_oe(link_if.m_scl_oe), .m_sda_oe(link_if.m_sda_oe), .s_scl_oe(link_if.s_scl_oe),
    .s_sda_oe(link_if.s_sda_oe), .scl(link_if.scl), .sda(link_if.sda));
  // Clock
  always #20 clk_sys_in = ~clk_sys_in;
  // Pops the oldest note and compares it when checking was asked
  task automatic chk_next(input logic [33:0] got);
    ent = exp_q.pop_front();
    if (ent[34] === 1'b1) `CHK(got, ent[33:0])
  endtask : chk_next
  // Result watcher: write responses, read responses and device register reads
  always @(posedge clk_sys_in) begin
    rd_p <= reg_rd;
    if (bvalid === 1'b1 && bready) chk_next({bresp, 32'h0});
    if (rvalid === 1'b1 && rready) chk_next({rresp, 32'h0});
    if (rd_p) chk_next({26'h0, reg_rdata});
  end
  // AXI4-Lite write, address and data offered together
  task automatic axi_wr(input tws_byte_t a, input tws_word_t d, input logic [1:0] r);
    exp_q.push_back({1'b1, r, 32'h0});
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr
  // AXI4-Lite read, response noted, data returned in rv
  task automatic m_rd(input tws_byte_t a, input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({1'b1, r, 32'h0});
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rready <= 1'b0;
  endtask : m_rd
  // Device register port write and read
  task automatic s_wr(input tws_byte_t a, input tws_byte_t d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask : s_wr
  task automatic s_rd(input tws_byte_t a, input logic c, input tws_byte_t x);
    exp_q.push_back({c, 26'h0, x});
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    @(posedge clk_sys_in);
    sv = reg_rdata;
  endtask : s_rd
  // Controller command, then poll until the controller is no longer busy
  task automatic m_cmd(input tws_op_e op, input logic ack);
    axi_wr(OFS_CMD, {29'h0, ack, op}, RESP_OKAY);
    do m_rd(OFS_MSTAT);
    while (rv[0] !== 1'b0);
  endtask : m_cmd
  task automatic m_addr(input logic [6:0] a, input logic rw);
    m_cmd(OP_START, 1'b0);
    axi_wr(OFS_TXDATA, {24'h0, a, rw}, RESP_OKAY);
    m_cmd(OP_WRITE, 1'b0);
  endtask : m_addr
  task automatic wait_irq;
    while (irq !== 1'b1) @(posedge clk_sys_in);
  endtask : wait_irq
  task automatic end_of_test;
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    failures++;
    $display("ERROR %0t: timeout", $time);
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(98));
    own = 7'($urandom);
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    s_rd(OFS_STATUS, 1'b1, 8'h00);
    s_rd(8'h30, 1'b1, 8'h00);
    axi_wr(8'h10, 32'h0, RESP_SLVERR);
    m_rd(8'h10, RESP_SLVERR);
    s_wr(OFS_OWN_ADDR, {own, 1'b1});
    s_rd(OFS_OWN_ADDR, 1'b1, {own, 1'b0});
    s_wr(OFS_CTRL, 8'hff);
    s_rd(OFS_CTRL, 1'b1, CTRL_MASK);
    s_wr(OFS_CTRL, 8'h80);
    $display("test registers done");
    m_addr(own ^ 7'h01, 1'b0);
    `CHK(rv[1], 1'b1)
    s_rd(OFS_STATUS, 1'b1, 8'h20);
    `CHK(irq, 1'b0)
    m_cmd(OP_STOP, 1'b0);
    s_rd(OFS_STATUS, 1'b1, 8'h00);
    $display("test foreign address done");
    m_addr(own, 1'b0);
    `CHK(rv[1], 1'b0)
    wait_irq();
    s_rd(OFS_STATUS, 1'b1, 8'he0);
    s_wr(OFS_CTRL, 8'h80);
    s_rd(OFS_DATA, 1'b0, 8'h00);
    `CHK(irq, 1'b0)
    d0 = 8'($urandom);
    axi_wr(OFS_TXDATA, {24'h0, d0}, RESP_OKAY);
    m_cmd(OP_WRITE, 1'b0);
    `CHK(rv[1], 1'b0)
    wait_irq();
    s_rd(OFS_STATUS, 1'b1, 8'ha0);
    s_rd(OFS_DATA, 1'b1, d0);
    s_wr(OFS_CTRL, 8'h88);
    d0 = 8'($urandom);
    axi_wr(OFS_TXDATA, {24'h0, d0}, RESP_OKAY);
    m_cmd(OP_WRITE, 1'b0);
    `CHK(rv[1], 1'b1)
    wait_irq();
    s_rd(OFS_DATA, 1'b1, d0);
    m_cmd(OP_STOP, 1'b0);
    s_rd(OFS_STATUS, 1'b0, 8'h00);
    `CHK(sv[ST_BUSY_BIT], 1'b0)
    $display("test device receive done");
    m_addr(own, 1'b1);
    wait_irq();
    s_rd(OFS_STATUS, 1'b1, 8'he4);
    s_wr(OFS_CTRL, 8'h90);
    d0 = 8'($urandom);
    s_wr(OFS_DATA, d0);
    m_cmd(OP_READ, 1'b0);
    m_rd(OFS_RXDATA);
    `CHK(rv[7:0], d0)
    wait_irq();
    s_rd(OFS_STATUS, 1'b1, 8'ha4);
    d0 = 8'($urandom);
    s_wr(OFS_DATA, d0);
    m_cmd(OP_READ, 1'b1);
    m_rd(OFS_RXDATA);
    `CHK(rv[7:0], d0)
    s_rd(OFS_STATUS, 1'b1, 8'ha5);
    s_wr(OFS_CTRL, 8'h80);
    s_rd(OFS_DATA, 1'b0, 8'h00);
    m_cmd(OP_STOP, 1'b0);
    s_rd(OFS_STATUS, 1'b0, 8'h00);
    `CHK(sv[ST_BUSY_BIT], 1'b0)
    $display("test device transmit done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
